/* rtl/module_sideband_ctrl.sv */
`timescale 1ns/100ps
module module_sideband_ctrl
  import sideband_pkg::*;
#(
  parameter int RESET_MIN = RESET_MIN_CYC,
  parameter int INIT_TIME = INIT_CYC,
  parameter int MODE_TIME = MODE_CYC
) (
  // clock and reset
  input  wire logic             sys_clk,
  input  wire logic             arst_n,
  // host link
  sideband_if.device            link,
  // lane side
  input  wire logic [LANES-1:0] rx_loss,
  input  wire logic [LANES-1:0] tx_input_weak,
  output logic      [LANES-1:0] rx_squelch,
  output logic      [LANES-1:0] tx_off,
  output logic                  low_power
);

  // ****************************************************************
  // state
  // ****************************************************************
  seq_state_t       seq_r, seq_nxt;           // reset sequencer
  logic [CNT_W-1:0] cnt_r, cnt_nxt;           // reset / init counter
  logic [7:0]       ctrl_r, ctrl_nxt;         // soft control
  logic [3:0]       flag_r, flag_nxt;         // status flags
  logic [LANES-1:0] loss_q_r;                 // last rx loss
  logic             rsp_v_r, rsp_v_nxt;       // answer strobe
  logic [7:0]       rsp_d_r, rsp_d_nxt;       // answer data
  logic             irq_r, irq_nxt;           // pin low request
  logic [LANES-1:0] rxsq_r, rxsq_nxt;         // rx squelch
  logic [LANES-1:0] txoff_r, txoff_nxt;       // tx off
  logic             lp_r, lp_nxt;             // low power
  logic [CNT_W-1:0] mode_r, mode_nxt;         // mode response delay
  logic             txd_r, txd_nxt;           // effective tx disable
  logic             lpr_r, lpr_nxt;           // effective lp request

  // ****************************************************************
  // sequencer, registers and flags
  // ****************************************************************
  logic             transmit_disable;
  logic             low_power_request;
  logic             sel_ok;
  logic             rd_status;

  always_comb
  begin
    seq_nxt  = seq_r;
    cnt_nxt  = cnt_r;
    ctrl_nxt = ctrl_r;
    flag_nxt = flag_r;
    rsp_v_nxt = 1'b0;
    rsp_d_nxt = rsp_d_r;
    // select is pulled high when undriven by the interface
    sel_ok    = !link.module_select_n && (seq_r == ST_RUN);
    rd_status = 1'b0;
    case (seq_r)
      ST_RUN:
      begin
        // count low time of reset pin
        if (!link.module_reset_n)
        begin
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r >= CNT_W'(RESET_MIN - 1))
            seq_nxt = ST_HOLD;
        end
        else
          cnt_nxt = '0;
      end
      ST_HOLD:
      begin
        // full reset of user settings while held
        ctrl_nxt = CTRL_RESET;
        flag_nxt = 4'h1;
        cnt_nxt  = '0;
        if (link.module_reset_n)
          seq_nxt = ST_INIT;
      end
      ST_INIT:
      begin
        // completion interval from release edge
        cnt_nxt = cnt_r + 1'b1;
        if (!link.module_reset_n)
        begin
          seq_nxt = ST_HOLD;
          cnt_nxt = '0;
        end
        else if (cnt_r >= CNT_W'(INIT_TIME - 1))
        begin
          seq_nxt = ST_RUN;
          cnt_nxt = '0;
          flag_nxt[ST_NOT_READY] = 1'b0;
          flag_nxt[ST_INIT_FLAG] = 1'b1;
        end
      end
      default:
        seq_nxt = ST_HOLD;
    endcase
    // serial access, only when selected and not in reset
    if (link.cmd_valid && sel_ok)
    begin
      if (link.cmd_write)
      begin
        if (link.cmd_addr == REG_CTRL)
          ctrl_nxt = link.cmd_wdata;
      end
      else
      begin
        rsp_v_nxt = 1'b1;
        case (link.cmd_addr)
          REG_STATUS:
          begin
            rsp_d_nxt = {4'h0, flag_r};
            rd_status = 1'b1;
          end
          REG_CTRL: rsp_d_nxt = ctrl_r;
          REG_LOSS: rsp_d_nxt = {{(8-LANES){1'b0}}, rx_loss};
          default:  rsp_d_nxt = 8'h00;
        endcase
      end
    end
    // reading clears latched flags; a new event wins
    if (rd_status)
      flag_nxt[3:1] = 3'b000;
    if (seq_r == ST_RUN)
    begin
      if (rx_loss != loss_q_r)
        flag_nxt[ST_LOSS_FLAG] = 1'b1;
      if (|(tx_input_weak & ~{LANES{ctrl_r[CT_TXSQ_OFF]}}))
        flag_nxt[ST_TXLOSS_FLAG] = 1'b1;
    end
  end

  // ****************************************************************
  // pin meaning and outputs
  // ****************************************************************
  always_comb
  begin
    // function = pin in its meaning OR soft bit
    transmit_disable  = (ctrl_r[CT_PIN_TXOFF] & link.lowpower_txoff_input)
                        | ctrl_r[CT_SOFT_TXOFF];
    low_power_request = (!ctrl_r[CT_PIN_TXOFF] & link.lowpower_txoff_input)
                        | ctrl_r[CT_SOFT_LPWR];
    // response delay for mode-dependent outputs
    mode_nxt = mode_r;
    txd_nxt  = txd_r;
    lpr_nxt  = lpr_r;
    if (transmit_disable != txd_r || low_power_request != lpr_r)
    begin
      mode_nxt = mode_r + 1'b1;
      if (mode_r >= CNT_W'(MODE_TIME - 1))
      begin
        txd_nxt  = transmit_disable;
        lpr_nxt  = low_power_request;
        mode_nxt = '0;
      end
    end
    else
      mode_nxt = '0;
    // power state: override bits decide when neither pin nor soft bit asks
    if (lpr_r)
      lp_nxt = 1'b1;
    else if (ctrl_r[CT_PWR_OVR])
      lp_nxt = ctrl_r[CT_PWR_SET];
    else
      lp_nxt = 1'b0;
    // transmitters off for disable, reset or tx squelch; low power alone keeps them
    txoff_nxt = {LANES{txd_r | (seq_r != ST_RUN)}}
                | (tx_input_weak & ~{LANES{ctrl_r[CT_TXSQ_OFF]}});
    // rx squelch on by default
    rxsq_nxt  = rx_loss & ~{LANES{ctrl_r[CT_RXSQ_OFF]}};
    // output: interrupt meaning after reset, rx loss if reprogrammed
    if (ctrl_r[CT_OUT_RXLOSS])
      irq_nxt = |rx_loss;
    else
      irq_nxt = |flag_nxt[3:1];
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      seq_r    <= ST_HOLD;
      cnt_r    <= '0;
      ctrl_r   <= CTRL_RESET;
      flag_r   <= 4'h1;
      loss_q_r <= '0;
      rsp_v_r  <= 1'b0;
      rsp_d_r  <= 8'h00;
      irq_r    <= 1'b0;
      rxsq_r   <= '0;
      txoff_r  <= '1;
      lp_r     <= 1'b1;
      mode_r   <= '0;
      txd_r    <= 1'b0;
      lpr_r    <= 1'b1;
    end
    else
    begin
      seq_r    <= seq_nxt;
      cnt_r    <= cnt_nxt;
      ctrl_r   <= ctrl_nxt;
      flag_r   <= flag_nxt;
      loss_q_r <= rx_loss;
      rsp_v_r  <= rsp_v_nxt;
      rsp_d_r  <= rsp_d_nxt;
      irq_r    <= irq_nxt;
      rxsq_r   <= rxsq_nxt;
      txoff_r  <= txoff_nxt;
      lp_r     <= lp_nxt;
      mode_r   <= mode_nxt;
      txd_r    <= txd_nxt;
      lpr_r    <= lpr_nxt;
    end
  end

  // presence pin grounded inside the module
  assign link.presence_n_o       = 1'b0;
  assign link.presence_n_oe      = 1'b1;
  // open collector: only ever pulls low
  assign link.irq_or_rxloss_n_o  = 1'b0;
  assign link.irq_or_rxloss_n_oe = irq_r;
  assign link.rsp_valid          = rsp_v_r;
  assign link.rsp_rdata          = rsp_d_r;
  assign rx_squelch              = rxsq_r;
  assign tx_off                  = txoff_r;
  assign low_power               = lp_r;

endmodule

/* rtl/sideband_pkg.sv */
package sideband_pkg;

  // ****************************************************************
  // widths and timing
  // ****************************************************************
  localparam int          LANES          = 4;        // optical lanes
  localparam int          CLK_PERIOD_NS  = 10;       // sys_clk period
  localparam int          RESET_MIN_NS   = 200;      // least reset pulse
  localparam int          RESET_MIN_CYC  = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          INIT_NS        = 1000;     // reset completion time
  localparam int          INIT_CYC       = INIT_NS / CLK_PERIOD_NS;
  localparam int          MODE_NS        = 100;      // mode-change response
  localparam int          MODE_CYC       = MODE_NS / CLK_PERIOD_NS;
  localparam int          CNT_W          = 12;       // counter width

  // ****************************************************************
  // serial register space (byte offsets) and fields
  // ****************************************************************
  localparam logic [7:0]  REG_STATUS     = 8'h00;    // status / flags, read clears
  localparam logic [7:0]  REG_CTRL       = 8'h01;    // soft control
  localparam logic [7:0]  REG_LOSS       = 8'h02;    // per-lane loss levels
  localparam int          ST_NOT_READY   = 0;        // init pending
  localparam int          ST_INIT_FLAG   = 1;        // init done flag
  localparam int          ST_LOSS_FLAG   = 2;        // rx loss change flag
  localparam int          ST_TXLOSS_FLAG = 3;        // tx input loss flag
  localparam int          CT_SOFT_TXOFF  = 0;        // soft transmit disable
  localparam int          CT_SOFT_LPWR   = 1;        // soft low power
  localparam int          CT_PIN_TXOFF   = 2;        // pin acts as transmit disable
  localparam int          CT_OUT_RXLOSS  = 3;        // output acts as rx loss
  localparam int          CT_RXSQ_OFF    = 4;        // rx squelch disable
  localparam int          CT_TXSQ_OFF    = 5;        // tx squelch disable
  localparam int          CT_PWR_OVR     = 6;        // power override
  localparam int          CT_PWR_SET     = 7;        // power set (low when 1)
  localparam logic [7:0]  CTRL_RESET     = 8'h00;    // control default

  // ****************************************************************
  // device reset sequencer states
  // ****************************************************************
  typedef enum logic [1:0] {
    ST_RUN  = 2'b10,
    ST_HOLD = 2'b01,
    ST_INIT = 2'b11
  } seq_state_t;

endpackage

/* rtl/sideband_if.sv */
`timescale 1ns/100ps
interface sideband_if;
  import sideband_pkg::*;

  // host driven pins (driven-level and drive enable)
  logic module_select_n_o;
  logic module_select_n_oe;
  logic module_reset_n_o;
  logic module_reset_n_oe;
  logic lowpower_txoff_o;
  logic lowpower_txoff_oe;
  // module driven pins
  logic presence_n_o;
  logic presence_n_oe;
  logic irq_or_rxloss_n_o;
  logic irq_or_rxloss_n_oe;
  // serial command channel (word level)
  logic       cmd_valid;
  logic       cmd_write;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_wdata;
  logic       rsp_valid;
  logic [7:0] rsp_rdata;

  // resolved pin levels: pull-ups where nobody drives
  logic module_select_n;
  logic module_reset_n;
  logic lowpower_txoff_input;
  logic presence_n;
  logic irq_or_rxloss_n;
  assign module_select_n      = module_select_n_oe ? module_select_n_o : 1'b1;
  assign module_reset_n       = module_reset_n_oe ? module_reset_n_o : 1'b1;
  assign lowpower_txoff_input = lowpower_txoff_oe ? lowpower_txoff_o : 1'b1;
  assign presence_n           = presence_n_oe ? presence_n_o : 1'b1;
  assign irq_or_rxloss_n      = irq_or_rxloss_n_oe ? irq_or_rxloss_n_o : 1'b1;

  modport device (
    input  module_select_n, module_reset_n, lowpower_txoff_input,
    output presence_n_o, presence_n_oe, irq_or_rxloss_n_o, irq_or_rxloss_n_oe,
    input  cmd_valid, cmd_write, cmd_addr, cmd_wdata,
    output rsp_valid, rsp_rdata
  );
  modport host (
    output module_select_n_o, module_select_n_oe, module_reset_n_o, module_reset_n_oe,
    output lowpower_txoff_o, lowpower_txoff_oe,
    input  presence_n, irq_or_rxloss_n,
    output cmd_valid, cmd_write, cmd_addr, cmd_wdata,
    input  rsp_valid, rsp_rdata
  );
endinterface

/* rtl/host_sideband_ctrl.sv */
`timescale 1ns/100ps
module host_sideband_ctrl
  import sideband_pkg::*;
#(
  parameter int SEL_TIME = MODE_CYC  // select assert / deassert wait
) (
  // clock and reset
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  // user controls
  input  wire logic       want_select,
  input  wire logic       want_reset,
  input  wire logic       want_lowpower_txoff,
  input  wire logic       req_valid,
  input  wire logic       req_write,
  input  wire logic [7:0] req_addr,
  input  wire logic [7:0] req_wdata,
  output logic            req_taken,
  output logic            ans_valid,
  output logic [7:0]      ans_data,
  output logic            present,
  output logic            attention,
  // module link
  sideband_if.host        link
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic             sel_r, sel_nxt;         // select drive
  logic [CNT_W-1:0] wait_r, wait_nxt;       // select settle timer
  logic             rst_r, rst_nxt;         // reset drive
  logic             lpt_r, lpt_nxt;         // dual pin level
  logic             cv_r, cv_nxt;           // command strobe
  logic             cw_r, cw_nxt;
  logic [7:0]       ca_r, ca_nxt;
  logic [7:0]       cd_r, cd_nxt;
  logic             tk_r, tk_nxt;
  logic             av_r, av_nxt;
  logic [7:0]       ad_r, ad_nxt;
  logic             pr_r, pr_nxt;
  logic             at_r, at_nxt;

  // ****************************************************************
  // next values
  // ****************************************************************
  always_comb
  begin
    sel_nxt  = want_select;
    rst_nxt  = want_reset;
    lpt_nxt  = want_lowpower_txoff;
    // restart the settle timer on every select change
    if (want_select != sel_r)
      wait_nxt = '0;
    else if (wait_r < CNT_W'(SEL_TIME))
      wait_nxt = wait_r + 1'b1;
    else
      wait_nxt = wait_r;
    // issue only when selected, settled, not in reset, and still so next cycle
    tk_nxt = req_valid && want_select && sel_r && !want_reset && !rst_r
             && (wait_r >= CNT_W'(SEL_TIME));
    cv_nxt = tk_nxt;
    cw_nxt = req_write;
    ca_nxt = req_addr;
    cd_nxt = req_wdata;
    av_nxt = link.rsp_valid;
    ad_nxt = link.rsp_valid ? link.rsp_rdata : ad_r;
    pr_nxt = !link.presence_n;
    // status ignored while reset is driven
    at_nxt = !rst_r && !link.irq_or_rxloss_n;
  end

  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sel_r  <= 1'b0;
      wait_r <= '0;
      rst_r  <= 1'b0;
      lpt_r  <= 1'b1;
      cv_r   <= 1'b0;
      cw_r   <= 1'b0;
      ca_r   <= 8'h00;
      cd_r   <= 8'h00;
      tk_r   <= 1'b0;
      av_r   <= 1'b0;
      ad_r   <= 8'h00;
      pr_r   <= 1'b0;
      at_r   <= 1'b0;
    end
    else
    begin
      sel_r  <= sel_nxt;
      wait_r <= wait_nxt;
      rst_r  <= rst_nxt;
      lpt_r  <= lpt_nxt;
      cv_r   <= cv_nxt;
      cw_r   <= cw_nxt;
      ca_r   <= ca_nxt;
      cd_r   <= cd_nxt;
      tk_r   <= tk_nxt;
      av_r   <= av_nxt;
      ad_r   <= ad_nxt;
      pr_r   <= pr_nxt;
      at_r   <= at_nxt;
    end
  end

  // pins: drive select and reset low as active-low, release otherwise
  assign link.module_select_n_o  = 1'b0;
  assign link.module_select_n_oe = sel_r;
  assign link.module_reset_n_o   = 1'b0;
  assign link.module_reset_n_oe  = rst_r;
  assign link.lowpower_txoff_o   = lpt_r;
  assign link.lowpower_txoff_oe  = 1'b1;
  assign link.cmd_valid          = cv_r;
  assign link.cmd_write          = cw_r;
  assign link.cmd_addr           = ca_r;
  assign link.cmd_wdata          = cd_r;
  assign req_taken               = tk_r;
  assign ans_valid               = av_r;
  assign ans_data                = ad_r;
  assign present                 = pr_r;
  assign attention               = at_r;

endmodule

/* dv/sideband_sva.sv */
`timescale 1ns/100ps
module sideband_sva (
  // clock and reset
  input logic sys_clk,
  input logic arst_n,
  // host driven pins
  input logic module_select_n,
  input logic module_select_n_oe,
  input logic module_reset_n,
  input logic lowpower_txoff_input,
  input logic lowpower_txoff_oe,
  // module driven pins
  input logic presence_n,
  input logic irq_or_rxloss_n,
  input logic irq_or_rxloss_n_o,
  input logic irq_or_rxloss_n_oe,
  // serial channel
  input logic cmd_valid,
  input logic cmd_write,
  input logic rsp_valid
);
  // ****************************************************************
  // one clock domain for every property
  // ****************************************************************
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  // ****************************************************************
  // pin level checks
  // ****************************************************************
  a_presence_tied_low: assert property (presence_n == 1'b0)
    else $error("presence pin not low while inserted");
  a_select_pull_high: assert property (!module_select_n_oe |-> module_select_n)
    else $error("undriven select does not read high");
  a_lowpower_pull_high: assert property (!lowpower_txoff_oe |-> lowpower_txoff_input)
    else $error("undriven low power pin does not read high");
  a_irq_open_drain: assert property (irq_or_rxloss_n_oe |-> !irq_or_rxloss_n_o)
    else $error("irq pin driven high");

  // ****************************************************************
  // serial channel checks
  // ****************************************************************
  a_answer_needs_select: assert property
    (rsp_valid |-> $past(cmd_valid && !cmd_write && !module_select_n))
    else $error("answer without a selected read");
  a_cmd_only_selected: assert property (cmd_valid |-> !module_select_n)
    else $error("command while deselected");
  a_select_settle_wait: assert property ($fell(module_select_n) |-> !cmd_valid [*8])
    else $error("command too soon after select");
  a_no_cmd_in_reset: assert property (!module_reset_n |-> !cmd_valid)
    else $error("command during module reset");

  // ****************************************************************
  // reset completion seen on the irq pin
  // ****************************************************************
  a_reset_done_irq: assert property
    ($rose(module_reset_n) |-> irq_or_rxloss_n [*3] ##[1:12] !irq_or_rxloss_n)
    else $error("reset completion not posted in time");

  // main scenarios reached
  c_read_answer:  cover property (rsp_valid);
  c_write_cmd:    cover property (cmd_valid && cmd_write);
  c_module_reset: cover property ($rose(module_reset_n));
  c_irq_posted:   cover property ($fell(irq_or_rxloss_n));
endmodule

/* dv/module_sideband_control_tb.sv */
`timescale 1ns/100ps
module module_sideband_control_tb;
  import sideband_pkg::*;
  // ****************************************************************
  // signals and counters
  // ****************************************************************
  localparam int MODE_T = 2;             // shortened mode response
  logic             sys_clk;             // system clock
  logic             arst_n;              // async reset
  logic             want_select;         // host user controls
  logic             want_reset;
  logic             want_lowpower_txoff;
  logic             req_valid;           // host command request
  logic             req_write;
  logic [7:0]       req_addr;
  logic [7:0]       req_wdata;
  logic             req_taken;           // host answers
  logic             ans_valid;
  logic [7:0]       ans_data;
  logic             present;
  logic             attention;
  logic [LANES-1:0] rx_loss;             // lane side stimulus
  logic [LANES-1:0] tx_input_weak;
  logic [LANES-1:0] rx_squelch;          // lane side results
  logic [LANES-1:0] tx_off;
  logic             low_power;
  int               errors;
  int               num_checks;

  // ****************************************************************
  // both ends joined by the interface, checker beside it
  // ****************************************************************
  sideband_if u_sideband_if ();
  module_sideband_ctrl #(.RESET_MIN(2), .INIT_TIME(4), .MODE_TIME(MODE_T)) u_module_sideband_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .link(u_sideband_if.device), .rx_loss(rx_loss),
    .tx_input_weak(tx_input_weak), .rx_squelch(rx_squelch), .tx_off(tx_off),
    .low_power(low_power));
  host_sideband_ctrl u_host_sideband_ctrl (
    .sys_clk(sys_clk), .arst_n(arst_n), .want_select(want_select), .want_reset(want_reset),
    .want_lowpower_txoff(want_lowpower_txoff), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_taken(req_taken),
    .ans_valid(ans_valid), .ans_data(ans_data), .present(present), .attention(attention),
    .link(u_sideband_if.host));
  sideband_sva u_sideband_sva (
    .sys_clk(sys_clk), .arst_n(arst_n),
    .module_select_n(u_sideband_if.module_select_n),
    .module_select_n_oe(u_sideband_if.module_select_n_oe),
    .module_reset_n(u_sideband_if.module_reset_n),
    .lowpower_txoff_input(u_sideband_if.lowpower_txoff_input),
    .lowpower_txoff_oe(u_sideband_if.lowpower_txoff_oe),
    .presence_n(u_sideband_if.presence_n), .irq_or_rxloss_n(u_sideband_if.irq_or_rxloss_n),
    .irq_or_rxloss_n_o(u_sideband_if.irq_or_rxloss_n_o),
    .irq_or_rxloss_n_oe(u_sideband_if.irq_or_rxloss_n_oe),
    .cmd_valid(u_sideband_if.cmd_valid), .cmd_write(u_sideband_if.cmd_write),
    .rsp_valid(u_sideband_if.rsp_valid));

  // ****************************************************************
  // helpers: timing, compares, serial transfers
  // ****************************************************************
  // step n edges, then land just after the last one
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  // long enough for a pin or soft change to reach the lanes
  task automatic settle();
    tick(MODE_T + 8);
  endtask
  // byte result compare
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // single flag compare
  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h00, got}, {7'h00, exp});
  endtask
  // one serial byte: request held until taken, read waits for answer
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    int n;
    req_valid = 1'b1;
    req_write = wr;
    req_addr  = addr;
    req_wdata = wdata;
    n = 0;
    while (req_taken !== 1'b1 && n < 100)
    begin
      tick(1);
      n++;
    end
    req_valid = 1'b0;
    chk_bit(req_taken, 1'b1);
    rdata = 8'h00;
    n = 0;
    while (!wr && ans_valid !== 1'b1 && n < 20)
    begin
      tick(1);
      n++;
    end
    if (!wr)
    begin
      chk_bit(ans_valid, 1'b1);
      rdata = ans_data;
    end
    tick(2);
  endtask
  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    logic [7:0] d;
    xfer(1'b1, addr, data, d);
  endtask
  task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
    logic [7:0] d;
    xfer(1'b0, addr, 8'h00, d);
    chk_byte(d, exp);
  endtask
  // bounded wait for the attention level
  task automatic wait_att(input logic v);
    int n;
    n = 0;
    while (attention !== v && n < 200)
    begin
      tick(1);
      n++;
    end
    chk_bit(attention, v);
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // power-up completion, defaults, flag cleared by read
  task automatic t_power_up();
    wait_att(1'b1);
    chk_bit(present, 1'b1);
    rd_chk(REG_STATUS, 8'h02);
    wait_att(1'b0);
    rd_chk(REG_CTRL, CTRL_RESET);
    settle();
    chk_byte({4'h0, tx_off}, 8'h00);
    chk_bit(low_power, 1'b0);
  endtask
  // deselected: request held back until select has settled again
  task automatic t_select();
    want_select = 1'b0;
    tick(2);
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr  = REG_CTRL;
    tick(12);
    chk_bit(req_taken, 1'b0);
    want_select = 1'b1;
    tick(11);
    chk_bit(req_taken, 1'b0);
    tick(1);
    chk_bit(req_taken, 1'b1);
    req_valid = 1'b0;
    tick(2);
    chk_bit(ans_valid, 1'b1);
    chk_byte(ans_data, CTRL_RESET);
    tick(2);
  endtask
  // pin as low power request, then soft bits
  task automatic t_lowpower();
    want_lowpower_txoff = 1'b1;
    settle();
    chk_bit(low_power, 1'b1);
    chk_byte({4'h0, tx_off}, 8'h00);
    want_lowpower_txoff = 1'b0;
    wr(REG_CTRL, 8'h01);
    settle();
    chk_byte({4'h0, tx_off}, 8'h0f);
    wr(REG_CTRL, 8'h02);
    settle();
    chk_bit(low_power, 1'b1);
    chk_byte({4'h0, tx_off}, 8'h00);
  endtask
  // meaning switch while high and while low, then override
  task automatic t_txoff_pin();
    want_lowpower_txoff = 1'b1;
    wr(REG_CTRL, 8'h00);
    settle();
    wr(REG_CTRL, 8'h04);
    settle();
    chk_byte({4'h0, tx_off}, 8'h0f);
    chk_bit(low_power, 1'b0);
    want_lowpower_txoff = 1'b0;
    settle();
    chk_byte({4'h0, tx_off}, 8'h00);
    wr(REG_CTRL, 8'h00);
    wr(REG_CTRL, 8'hc4);
    settle();
    chk_bit(low_power, 1'b1);
    chk_byte({4'h0, tx_off}, 8'h00);
    wr(REG_CTRL, 8'h04);
    settle();
    chk_bit(low_power, 1'b0);
    wr(REG_CTRL, 8'h00);
  endtask
  // rx loss: squelch, flag, rx loss meaning of the pin
  task automatic t_rx_loss();
    logic [7:0] d;
    rx_loss = 4'h5;
    settle();
    chk_byte({4'h0, rx_squelch}, 8'h05);
    chk_bit(attention, 1'b1);
    rd_chk(REG_LOSS, 8'h05);
    rd_chk(REG_STATUS, 8'h04);
    wr(REG_CTRL, 8'h08);
    settle();
    chk_bit(attention, 1'b1);
    rx_loss = 4'h0;
    settle();
    chk_bit(attention, 1'b0);
    rx_loss = 4'h8;
    wr(REG_CTRL, 8'h18);
    settle();
    chk_bit(attention, 1'b1);
    chk_byte({4'h0, rx_squelch}, 8'h00);
    rx_loss = 4'h0;
    wr(REG_CTRL, 8'h00);
    xfer(1'b0, REG_STATUS, 8'h00, d);
    rd_chk(REG_STATUS, 8'h00);
    wait_att(1'b0);
  endtask
  // weak electrical input squelches its transmitter
  task automatic t_tx_squelch();
    logic [7:0] d;
    tx_input_weak = 4'h3;
    settle();
    chk_byte({4'h0, tx_off}, 8'h03);
    rd_chk(REG_STATUS, 8'h08);
    wr(REG_CTRL, 8'h20);
    settle();
    chk_byte({4'h0, tx_off}, 8'h00);
    tx_input_weak = 4'h0;
    wr(REG_CTRL, 8'h00);
    xfer(1'b0, REG_STATUS, 8'h00, d);
  endtask
  // module reset pin restores defaults and posts completion
  task automatic t_module_reset();
    wr(REG_CTRL, 8'h01);
    want_reset = 1'b1;
    tick(6);
    chk_byte({4'h0, tx_off}, 8'h0f);
    want_reset = 1'b0;
    wait_att(1'b1);
    rd_chk(REG_CTRL, CTRL_RESET);
    rd_chk(REG_STATUS, 8'h02);
    settle();
    chk_byte({4'h0, tx_off}, 8'h00);
  endtask

  // ****************************************************************
  // clock, run control and verdict
  // ****************************************************************
  task automatic stop_test();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
    begin
      $display("Test passed");
    end
    else
    begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // watchdog well beyond the expected few hundred cycles
  initial
  begin
    #200000;
    errors++;
    stop_test();
  end
  initial
  begin
    errors = 0;
    num_checks = 0;
    arst_n = 1'b0;
    want_select = 1'b1;
    want_reset = 1'b0;
    want_lowpower_txoff = 1'b0;
    req_valid = 1'b0;
    req_write = 1'b0;
    req_addr = 8'h00;
    req_wdata = 8'h00;
    rx_loss = 4'h0;
    tx_input_weak = 4'h0;
    tick(3);
    arst_n = 1'b1;
    t_power_up();
    t_select();
    t_lowpower();
    t_txoff_pin();
    t_rx_loss();
    t_tx_squelch();
    t_module_reset();
    stop_test();
  end
endmodule
